/* inc/hbc_pkg.sv */
// package of register map, field layout and timing constants for the half-bridge config bank
package hbc_pkg;

	// ****************************************
	// register offsets (7-bit serial address)
	// ****************************************
	localparam logic [6:0] ADDR_THRESHOLD = 7'h22; // open_load_threshold_ch1_8
	localparam logic [6:0] ADDR_GENERAL   = 7'h25; // general_control
	localparam logic [6:0] ADDR_ROUTE_A   = 7'h26; // generator_route_ch9_10
	localparam logic [6:0] ADDR_ROUTE_B   = 7'h27; // generator_route_ch11_12
	localparam logic [6:0] ADDR_OFFCUR_A  = 7'h28; // offstate_current_ch1_4
	localparam logic [6:0] ADDR_OFFCUR_B  = 7'h29; // offstate_current_ch5_8
	localparam logic [6:0] ADDR_TRIM      = 7'h2e; // lockable trim bits 7..4

	// ****************************************
	// field layout of general_control, plus the routing and trim field offsets
	// ****************************************
	localparam int GEN_MOD_HI  = 7;
	localparam int GEN_MOD_LO  = 6;
	localparam int GEN_DEV     = 5;
	localparam int GEN_RDCLR   = 4;
	localparam int GEN_UNLOCK  = 3;
	localparam int GEN_ERR     = 2;
	localparam int ROUTE_HI_LO = 3; // upper routing field at 5:3
	localparam int TRIM_LO     = 4; // trim bits sit at 7:4

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] REG_RST  = 8'h00;
	localparam logic [3:0] TRIM_RST = 4'h1; // dead-time source is feedback only in reset, then taken from one-time memory
	localparam logic [1:0] SS_OFF   = 2'h0;

	// ****************************************
	// serial frame: command byte then data byte
	// ****************************************
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] CMD_LAST   = 5'h07;
	localparam logic [4:0] DATA_FIRST = 5'h08;
	localparam logic [4:0] DATA_LAST  = 5'h0f;

	// ****************************************
	// timing: core clock and spread modulation rates
	// ****************************************
	localparam longint CLK_HZ     = 250_000_000;
	localparam longint SS1_MHZ    = 15_625_000; // 15.625 kHz in millihertz
	localparam longint SS2_MHZ    = 31_250_000; // 31.25 kHz
	localparam longint SS3_MHZ    = 62_500_000; // 62.5 kHz
	localparam longint SS1_CYC    = (CLK_HZ * 1000) / (2 * SS1_MHZ); // half period
	localparam longint SS2_CYC    = (CLK_HZ * 1000) / (2 * SS2_MHZ);
	localparam longint SS3_CYC    = (CLK_HZ * 1000) / (2 * SS3_MHZ);
	localparam int     SS_CNT_W   = 14;

endpackage : hbc_pkg

/* design/hbc_regs.sv */
// serially accessed configuration register bank of the half-bridge driver
`timescale 1ns/100ps

module hbc_regs
	import hbc_pkg::*;
#(
	parameter int unsigned SS_HALF1 = int'(SS1_CYC), // half period, 15.625 kHz
	parameter int unsigned SS_HALF2 = int'(SS2_CYC), // half period, 31.25 kHz
	parameter int unsigned SS_HALF3 = int'(SS3_CYC)  // half period, 62.5 kHz
) (
	input  wire logic        mclk_i,                      // core clock 250 MHz
	input  wire logic        rst_b_i,                     // async reset, active low
	input  wire logic        sclk_i,                      // serial clock pin
	input  wire logic        cs_b_i,                      // serial chip select, active low
	input  wire logic        sdi_i,                       // serial data in
	input  wire logic [3:0]  otp_trim_i,                  // trim defaults from one-time memory
	output logic             sdo_o,                       // serial data out
	output logic             sdo_oe_b_o,                  // sdo enable, low while driving
	output logic [7:0]       open_load_threshold_select_o, // per channel 1..8
	output logic [1:0]       spread_mod_select_o,         // spread modulation rate
	output logic             spread_deviation_select_o,   // 5 or 10 percent
	output logic             spread_phase_o,              // modulation up/down phase
	output logic             diag_clear_o,                // pulse: clear flags at address
	output logic [6:0]       diag_clear_addr_o,           // address being read
	output logic [11:0]      generator_route_select_o,    // ch12..ch9, 3 bits each
	output logic [7:0]       offstate_pullup_enable_o,    // per channel 1..8
	output logic [7:0]       offstate_pulldown_enable_o,  // per channel 1..8
	output logic             overcurrent_level_select_o,  // 1.3A or 1.7A
	output logic             overvoltage_level_select_o,  // overvoltage level
	output logic             discharge_current_select_o,  // discharge current level
	output logic             dead_time_source_select_o,   // fixed or feedback dead time
	output logic             spi_error_o                  // latched serial error
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [2:0]          sclk_s;   // [0],[1] synchroniser, [2] previous
		logic [2:0]          cs_s;
		logic [1:0]          sdi_s;
		logic [4:0]          bitcnt;
		logic [7:0]          shin;
		logic [7:0]          shout;
		logic [6:0]          addr;
		logic                wr;
		logic [7:0]          thr;
		logic [4:0]          ctl;      // general_control bits 7..3
		logic [5:0]          rt_a;
		logic [5:0]          rt_b;
		logic [7:0]          off_a;
		logic [7:0]          off_b;
		logic [3:0]          trim;
		logic                err;
		logic                otp_done;
		logic                sdo;
		logic                sdo_oe_b;
		logic                clr;
		logic [6:0]          clr_addr;
		logic [SS_CNT_W-1:0] ss_cnt;
		logic                ss_phase;
	} hbc_state_t;

	localparam hbc_state_t ST_RST = '{
		sclk_s: 3'h0, cs_s: 3'h7, sdi_s: 2'h0, bitcnt: 5'h00, shin: REG_RST,
		shout: REG_RST, addr: 7'h00, wr: 1'b0, thr: REG_RST, ctl: 5'h00,
		rt_a: 6'h00, rt_b: 6'h00, off_a: REG_RST, off_b: REG_RST, trim: TRIM_RST,
		err: 1'b0, otp_done: 1'b0, sdo: 1'b0, sdo_oe_b: 1'b1, clr: 1'b0,
		clr_addr: 7'h00, ss_cnt: '0, ss_phase: 1'b0
	};

	hbc_state_t s;
	hbc_state_t next_s;

	// helpers seen by the checks as well as by the next-state logic
	logic                sclk_rise;
	logic                sclk_fall;
	logic                cs_fall;
	logic                cs_rise;
	logic [7:0]          byte_in;
	logic                wr_now;
	logic                rd_gen_now;
	logic                frame_err;
	logic [SS_CNT_W-1:0] ss_lim;

	// ****************************************
	// read data mux; reserved bits read zero
	// ****************************************
	function automatic logic [7:0] read_mux(input hbc_state_t st, input logic [6:0] a);
		logic [7:0] d;
		d = REG_RST;
		unique case (a)
			ADDR_THRESHOLD: d = st.thr;
			ADDR_GENERAL:   d = {st.ctl, st.err, 2'b00};
			ADDR_ROUTE_A:   d = {2'b00, st.rt_a};
			ADDR_ROUTE_B:   d = {2'b00, st.rt_b};
			ADDR_OFFCUR_A:  d = st.off_a;
			ADDR_OFFCUR_B:  d = st.off_b;
			ADDR_TRIM:      d = {st.trim, 4'h0};
			default:        d = REG_RST;
		endcase
		return d;
	endfunction : read_mux

	// ****************************************
	// edge detection on synchronised pins (second stage onward only)
	// ****************************************
	assign sclk_rise  = s.sclk_s[1] & ~s.sclk_s[2];
	assign sclk_fall  = ~s.sclk_s[1] & s.sclk_s[2];
	assign cs_fall    = ~s.cs_s[1] & s.cs_s[2];
	assign cs_rise    = s.cs_s[1] & ~s.cs_s[2];
	assign byte_in    = {s.shin[6:0], s.sdi_s[1]};
	assign wr_now     = ~s.cs_s[1] & sclk_rise & (s.bitcnt == DATA_LAST) & s.wr;
	assign rd_gen_now = ~s.cs_s[1] & sclk_rise & (s.bitcnt == CMD_LAST) & ~byte_in[7]
		& (byte_in[6:0] == ADDR_GENERAL);
	assign frame_err  = cs_rise & (s.bitcnt != FRAME_BITS);

	// spread modulation half period for the selected rate
	always_comb begin
		unique case (s.ctl[GEN_MOD_HI-3:GEN_MOD_LO-3])
			2'h1:    ss_lim = SS_HALF1[SS_CNT_W-1:0];
			2'h2:    ss_lim = SS_HALF2[SS_CNT_W-1:0];
			2'h3:    ss_lim = SS_HALF3[SS_CNT_W-1:0];
			default: ss_lim = SS_HALF1[SS_CNT_W-1:0];
		endcase
	end

	// ****************************************
	// next state
	// ****************************************
	// one process for frame, registers and modulation so no field has two drivers
	always_comb begin
		next_s        = s;
		next_s.sclk_s = {s.sclk_s[1:0], sclk_i};
		next_s.cs_s   = {s.cs_s[1:0], cs_b_i};
		next_s.sdi_s  = {s.sdi_s[0], sdi_i};
		next_s.clr    = 1'b0;

		// trim defaults are taken once after reset release, never from reset itself
		if (!s.otp_done) begin
			next_s.trim     = otp_trim_i;
			next_s.otp_done = 1'b1;
		end

		// serial frame: command byte (rw, addr) then data byte, msb first
		if (cs_fall) begin
			next_s.bitcnt   = 5'h00;
			next_s.sdo      = 1'b0;
			next_s.sdo_oe_b = 1'b0;
		end else if (!s.cs_s[1] && sclk_rise && s.bitcnt <= FRAME_BITS) begin // one past 16 marks a long frame
			next_s.shin   = byte_in;
			next_s.bitcnt = s.bitcnt + 5'h01;
			if (s.bitcnt == CMD_LAST) begin
				next_s.wr    = byte_in[7];
				next_s.addr  = byte_in[6:0];
				next_s.shout = read_mux(s, byte_in[6:0]);
				if (!byte_in[7] && s.ctl[GEN_RDCLR-3]) begin
					next_s.clr      = 1'b1;
					next_s.clr_addr = byte_in[6:0];
				end
			end
			if (rd_gen_now)
				next_s.err = 1'b0;
			if (wr_now) begin
				// reserved bits are dropped, functional fields still stored, trim bits only while unlocked
				unique case (s.addr)
					ADDR_THRESHOLD: next_s.thr   = byte_in;
					ADDR_GENERAL:   next_s.ctl   = byte_in[7:3];
					ADDR_ROUTE_A:   next_s.rt_a  = byte_in[5:0];
					ADDR_ROUTE_B:   next_s.rt_b  = byte_in[5:0];
					ADDR_OFFCUR_A:  next_s.off_a = byte_in;
					ADDR_OFFCUR_B:  next_s.off_b = byte_in;
					ADDR_TRIM: begin
						if (s.ctl[GEN_UNLOCK-3])
							next_s.trim = byte_in[7:TRIM_LO];
					end
					default: ;
				endcase
			end
		end else if (!s.cs_s[1] && sclk_fall && s.bitcnt >= DATA_FIRST && s.bitcnt < FRAME_BITS) begin
			next_s.sdo   = s.shout[7];
			next_s.shout = {s.shout[6:0], 1'b0};
		end

		// a short or long frame is an error; the set wins over a read clear
		if (cs_rise)
			next_s.sdo_oe_b = 1'b1;
		if (frame_err)
			next_s.err = 1'b1;

		// triangular modulation phase, counter held at zero when spreading is off
		if (s.ctl[GEN_MOD_HI-3:GEN_MOD_LO-3] == SS_OFF) begin
			next_s.ss_cnt   = '0;
			next_s.ss_phase = 1'b0;
		end else if (s.ss_cnt >= ss_lim - 1'b1) begin
			next_s.ss_cnt   = '0;
			next_s.ss_phase = ~s.ss_phase;
		end else begin
			next_s.ss_cnt = s.ss_cnt + 1'b1;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			s <= ST_RST;
		else
			s <= next_s;
	end

	// ****************************************
	// outputs, all taken straight from state flops
	// ****************************************
	assign sdo_o                        = s.sdo;
	assign sdo_oe_b_o                   = s.sdo_oe_b;
	assign open_load_threshold_select_o = s.thr;
	assign spread_mod_select_o          = s.ctl[GEN_MOD_HI-3:GEN_MOD_LO-3];
	assign spread_deviation_select_o    = s.ctl[GEN_DEV-3];
	assign spread_phase_o               = s.ss_phase;
	assign diag_clear_o                 = s.clr;
	assign diag_clear_addr_o            = s.clr_addr;
	assign generator_route_select_o     = {s.rt_b, s.rt_a};
	assign overcurrent_level_select_o   = s.trim[3];
	assign overvoltage_level_select_o   = s.trim[2];
	assign discharge_current_select_o   = s.trim[1];
	assign dead_time_source_select_o    = s.trim[0];
	assign spi_error_o                  = s.err;

	// pull-up at odd bit, pull-down at even bit, four channels per register
	for (genvar i = 0; i < 4; i++) begin : g_pull
		assign offstate_pullup_enable_o[i]     = s.off_a[2*i+1];
		assign offstate_pulldown_enable_o[i]   = s.off_a[2*i];
		assign offstate_pullup_enable_o[i+4]   = s.off_b[2*i+1];
		assign offstate_pulldown_enable_o[i+4] = s.off_b[2*i];
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	trim_locked_a: assert property (
		wr_now && s.addr == ADDR_TRIM && !s.ctl[GEN_UNLOCK-3] && s.otp_done |=> $stable(s.trim))
		else $error("locked trim bits changed on write");

	trim_unlock_a: assert property (
		wr_now && s.addr == ADDR_TRIM && s.ctl[GEN_UNLOCK-3] |=> s.trim == $past(byte_in[7:4]))
		else $error("unlocked trim write not stored");

	trim_otp_a: assert property (
		$rose(s.otp_done) |-> s.trim == $past(otp_trim_i))
		else $error("trim not loaded from one-time memory");

	err_set_a: assert property (
		frame_err |=> spi_error_o && read_mux(s, ADDR_GENERAL) == {s.ctl, 3'b100})
		else $error("frame error not flagged");

	err_hold_a: assert property (
		spi_error_o && !rd_gen_now |=> spi_error_o)
		else $error("error flag dropped without a read");

	rd_clear_a: assert property (
		diag_clear_o |-> $past(s.ctl[GEN_RDCLR-3]) && $past(s.bitcnt) == CMD_LAST)
		else $error("flag clear without enable");

	ss_off_a: assert property (
		spread_mod_select_o == SS_OFF |=> !spread_phase_o && s.ss_cnt == '0)
		else $error("modulation running while disabled");

	ss_rate_a: assert property (
		spread_mod_select_o != SS_OFF && $stable(spread_mod_select_o) && s.ss_cnt == ss_lim - 1'b1
		|=> $changed(spread_phase_o) ##1 $stable(spread_phase_o))
		else $error("modulation phase off rate");

	route_wr_a: assert property (
		wr_now && s.addr == ADDR_ROUTE_A |=> generator_route_select_o[5:0] == $past(byte_in[5:0]))
		else $error("routing field not stored");

	pull_both_a: assert property (
		wr_now && s.addr == ADDR_OFFCUR_A && byte_in[1:0] == 2'b11
		|=> offstate_pullup_enable_o[0] && offstate_pulldown_enable_o[0])
		else $error("pull enables not both applied");

endmodule : hbc_regs

/* test/hbc_host_model.sv */
// behavioural serial host that frames commands into the config bank
`timescale 1ns/100ps

module hbc_host_model (
	input  wire logic mclk_i, // core clock, host steps on its falls
	input  wire logic sdo_i,  // serial data from the device
	output logic      sclk_o, // idle low, still between frames
	output logic      cs_b_o, // frame select, active low
	output logic      sdi_o   // command and data bits
);
	// ****************************************
	// frame engine
	// ****************************************
	initial begin
		sclk_o = 1'b0;
		cs_b_o = 1'b1;
		sdi_o  = 1'b0;
	end

	// six core cycles per half period keeps setup and hold well above three
	task automatic wait_half();
		repeat (6) @(negedge mclk_i);
	endtask : wait_half

	// n bits msb first; reply bits taken on the rises of bits 8..15
	task automatic xfer(input logic [15:0] frm, input int n, output logic [7:0] rd);
		rd = 8'h00;
		cs_b_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi_o = (i < 16) ? frm[15-i] : 1'b0;
			wait_half();
			sclk_o = 1'b1;
			if (i >= 8 && i < 16) rd[15-i] = sdo_i;
			wait_half();
			sclk_o = 1'b0;
		end
		wait_half();
		cs_b_o = 1'b1;
		sdi_o  = ~sdi_o; // line no longer held once the frame ends
		wait_half();
	endtask : xfer
endmodule : hbc_host_model

/* test/hbc_regs_tb.sv */
// self-checking bench for the half-bridge config bank
`timescale 1ns/100ps

module hbc_regs_tb
	import hbc_pkg::*;
();
	// short half periods keep the spread measurements brief
	localparam int unsigned HALF [4] = '{0, 40, 20, 10};
	logic        mclk_i, rst_b_i, sclk_i, cs_b_i, sdi_i, sdo_o, sdo_oe_b_o;
	logic        spread_deviation_select_o, spread_phase_o, diag_clear_o, spi_error_o;
	logic        overcurrent_level_select_o, overvoltage_level_select_o;
	logic        discharge_current_select_o, dead_time_source_select_o, clr_seen;
	logic        oe_low_seen;
	logic [1:0]  spread_mod_select_o;
	logic [3:0]  otp_trim_i;
	logic [6:0]  diag_clear_addr_o, clr_addr;
	logic [7:0]  open_load_threshold_select_o, offstate_pullup_enable_o;
	logic [7:0]  offstate_pulldown_enable_o, rdv;
	logic [11:0] generator_route_select_o;
	int          fail_count, check_count;

	// ****************************************
	// device and host
	// ****************************************
	hbc_regs #(.SS_HALF1(HALF[1]), .SS_HALF2(HALF[2]), .SS_HALF3(HALF[3])) u_hbc_regs (
		.mclk_i, .rst_b_i, .sclk_i, .cs_b_i, .sdi_i, .otp_trim_i, .sdo_o, .sdo_oe_b_o,
		.open_load_threshold_select_o, .spread_mod_select_o, .spread_deviation_select_o,
		.spread_phase_o, .diag_clear_o, .diag_clear_addr_o, .generator_route_select_o,
		.offstate_pullup_enable_o, .offstate_pulldown_enable_o, .overcurrent_level_select_o,
		.overvoltage_level_select_o, .discharge_current_select_o, .dead_time_source_select_o,
		.spi_error_o
	);
	hbc_host_model u_hbc_host_model (.mclk_i, .sdo_i(sdo_o), .sclk_o(sclk_i), .cs_b_o(cs_b_i), .sdi_o(sdi_i));

	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	// the clear pulse lasts one cycle, so it is caught here rather than polled
	always @(posedge mclk_i) begin
		if (diag_clear_o === 1'b1) begin
			clr_seen <= 1'b1;
			clr_addr <= diag_clear_addr_o;
		end
		// output enable must have dropped at some point inside a frame
		if (sdo_oe_b_o === 1'b0) begin
			oe_low_seen <= 1'b1;
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		u_hbc_host_model.xfer({1'b1, a, d}, 16, x);
	endtask : wr

	task automatic rdc(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		oe_low_seen = 1'b0;
		u_hbc_host_model.xfer({1'b0, a, 8'h00}, 16, d);
		chk({6'h00, oe_low_seen, sdo_oe_b_o, d}, {6'h00, 2'b11, e});
	endtask : rdc

	// cycles between two turns of the modulation phase
	task automatic meas(input int unsigned half);
		int   n;
		logic p;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			p = spread_phase_o;
			while (spread_phase_o === p && n < 200) begin
				@(negedge mclk_i);
				n++;
			end
		end
		chk(16'(n), 16'(half));
	endtask : meas

	task automatic reset_dut(input logic [3:0] otp);
		rst_b_i = 1'b0;
		otp_trim_i = otp;
		repeat (12) @(negedge mclk_i);
		rst_b_i = 1'b1;
		repeat (6) @(negedge mclk_i);
	endtask : reset_dut

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	// ****************************************
	// tests
	// ****************************************
	initial begin
		fail_count = 0;
		check_count = 0;
		clr_seen = 1'b0;
		clr_addr = 7'h00;
		oe_low_seen = 1'b0;
		reset_dut(4'ha);
		chk({4'h0, generator_route_select_o}, 16'h0000);
		chk({open_load_threshold_select_o, offstate_pullup_enable_o}, 16'h0000);
		chk({offstate_pulldown_enable_o, 3'h0, spread_mod_select_o, spread_deviation_select_o, spi_error_o,
			sdo_oe_b_o}, 16'h0001);
		chk({12'h0, overcurrent_level_select_o, overvoltage_level_select_o, discharge_current_select_o,
			dead_time_source_select_o}, 16'h000a);
		rdc(ADDR_TRIM, 8'ha0);
		rdc(ADDR_GENERAL, 8'h00);
		wr(ADDR_THRESHOLD, 8'ha5);
		chk({8'h0, open_load_threshold_select_o}, 16'h00a5);
		rdc(ADDR_THRESHOLD, 8'ha5);
		// every generator number on every routed channel
		for (int n = 0; n < 8; n++) begin
			wr(ADDR_ROUTE_A, {2'b00, 3'(n), 3'(7 - n)});
			wr(ADDR_ROUTE_B, {2'b00, 3'(n + 3), 3'(n + 5)});
			chk({4'h0, generator_route_select_o}, {4'h0, 3'(n + 3), 3'(n + 5), 3'(n), 3'(7 - n)});
		end
		// last pass left channel 12 on value 2 and channel 11 on value 4
		rdc(ADDR_ROUTE_B, 8'h14);
		wr(ADDR_ROUTE_A, 8'hff);
		rdc(ADDR_ROUTE_A, 8'h3f);
		chk({10'h0, generator_route_select_o[5:0]}, 16'h003f);
		wr(ADDR_OFFCUR_A, 8'hff);
		wr(ADDR_OFFCUR_B, 8'h96);
		chk({offstate_pullup_enable_o, offstate_pulldown_enable_o}, 16'h9f6f);
		rdc(ADDR_OFFCUR_A, 8'hff);
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_GENERAL, {2'(m), m[0], 5'h00});
			chk({13'h0, spread_mod_select_o, spread_deviation_select_o}, {13'h0, 2'(m), m[0]});
			rdc(ADDR_GENERAL, {2'(m), m[0], 5'h00});
			if (m > 0) meas(HALF[m]);
		end
		wr(ADDR_GENERAL, 8'h10);
		repeat (8) @(negedge mclk_i);
		chk({15'h0, spread_phase_o}, 16'h0000);
		clr_seen = 1'b0;
		rdc(ADDR_OFFCUR_B, 8'h96);
		chk({8'h0, clr_seen, clr_addr}, {8'h0, 1'b1, ADDR_OFFCUR_B});
		wr(ADDR_GENERAL, 8'h00);
		clr_seen = 1'b0;
		rdc(ADDR_OFFCUR_B, 8'h96);
		chk({15'h0, clr_seen}, 16'h0000);
		wr(ADDR_TRIM, 8'h50);
		rdc(ADDR_TRIM, 8'ha0);
		wr(ADDR_GENERAL, 8'h08);
		wr(ADDR_TRIM, 8'h5f);
		rdc(ADDR_TRIM, 8'h50);
		chk({15'h0, overcurrent_level_select_o}, 16'h0000);
		// a second power-up must discard the unlocked trim values
		reset_dut(4'h3);
		rdc(ADDR_TRIM, 8'h30);
		rdc(ADDR_GENERAL, 8'h00);
		u_hbc_host_model.xfer({1'b1, ADDR_THRESHOLD, 8'hff}, 10, rdv);
		chk({15'h0, spi_error_o}, 16'h0001);
		rdc(ADDR_THRESHOLD, 8'h00);
		chk({15'h0, spi_error_o}, 16'h0001);
		rdc(ADDR_GENERAL, 8'h04);
		chk({15'h0, spi_error_o}, 16'h0000);
		rdc(ADDR_GENERAL, 8'h00);
		// one bit too many: the write at the sixteenth bit lands, the error is still flagged
		u_hbc_host_model.xfer({1'b1, ADDR_THRESHOLD, 8'h3c}, 17, rdv);
		chk({7'h0, spi_error_o, open_load_threshold_select_o}, {7'h0, 1'b1, 8'h3c});
		rdc(ADDR_GENERAL, 8'h04);
		chk({15'h0, spi_error_o}, 16'h0000);
		wr(7'h30, 8'h55);
		rdc(7'h30, 8'h00);
		stop_test();
	end

	// a stuck run ends here well after the tests would have finished
	initial begin
		repeat (40000) @(posedge mclk_i);
		fail_count++;
		stop_test();
	end
endmodule : hbc_regs_tb
